// [io_line_pkg.sv]
// constants and types for the camera i/o line control block
package io_line_pkg;
	localparam int N_LINES = 4;
	localparam logic [7:0] ADDR_PIN_SEL    = 8'h00;
	localparam logic [7:0] ADDR_LINE_CFG   = 8'h04;
	localparam logic [7:0] ADDR_FILT_WIDTH = 8'h08;
	localparam logic [7:0] ADDR_LEVELS     = 8'h0C;
	localparam logic [7:0] ADDR_EXP_MODE   = 8'h10;
	localparam logic [7:0] ADDR_SOFT_IDX   = 8'h14;
	localparam logic [7:0] ADDR_SOFT_VAL   = 8'h18;
	localparam logic [7:0] ADDR_SOFT_WORD  = 8'h1C;
	localparam logic [7:0] ADDR_RX_SEL     = 8'h20;
	// line config field positions
	localparam int POS_DIR     = 0;
	localparam int POS_INV     = 1;
	localparam int POS_RAIL    = 2;
	localparam int POS_FKIND   = 3;
	localparam int POS_SRC     = 8;
	localparam int POS_LEVEL   = 16;
	localparam int POS_CIRCUIT = 24;
	localparam logic [4:0] SRC_RESET    = 5'h00;
	localparam logic [2:0] RX_RESET     = 3'h4;
	localparam logic [15:0] WIDTH_RESET = 16'h0000;
	localparam int CLK_MHZ = 100;
	localparam int CYC_PER_US = CLK_MHZ;
	typedef enum logic [4:0] {
		SRC_OFF = 5'b00000, SRC_LINE0 = 5'b00001, SRC_LINE1 = 5'b00010,
		SRC_LINE2 = 5'b00011, SRC_LINE3 = 5'b00100, SRC_SOFT0 = 5'b00101,
		SRC_SOFT1 = 5'b00110, SRC_SOFT2 = 5'b00111, SRC_SOFT3 = 5'b01000,
		SRC_CNT0 = 5'b01001, SRC_CNT1 = 5'b01010, SRC_GLUE0 = 5'b01011,
		SRC_GLUE1 = 5'b01100, SRC_EXPOSING = 5'b01101, SRC_TRIG_READY = 5'b01110,
		SRC_PPS = 5'b01111, SRC_UART_TX = 5'b10000
	} drive_src_t;
	typedef enum logic [1:0] {
		CIRC_TRI_STATE = 2'b00, CIRC_ISOLATED = 2'b01, CIRC_PULL_LOW = 2'b10
	} circuit_kind_t;
	typedef enum logic [1:0] {
		EXP_LINE = 2'b00, EXP_FIRST_ROW = 2'b01, EXP_EVERY_ROW = 2'b10
	} exposing_mode_t;
	typedef enum logic {
		FILT_DEGLITCH = 1'b0, FILT_DEBOUNCE = 1'b1
	} filter_kind_t;
endpackage

// [camera_io_line_control.sv]
// camera i/o line control: direction, polarity, filters, drive mux, soft bits
//
// Chosen here: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
module camera_io_line_control #(
	parameter logic [7:0] CIRCUIT_MAP = 8'b00_00_10_01,
	parameter logic [3:0] RAIL_CAPABLE = 4'b0100
) (
	input  wire logic        i_clk_sys,
	input  wire logic        i_rst,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic [3:0]  i_pin,
	output logic [3:0]       o_pin,
	output logic [3:0]       o_pin_oe,
	output logic [3:0]       o_aux_rail_enable,
	input  wire logic [1:0]  i_count_unit_running,
	input  wire logic [1:0]  i_glue_logic_out,
	input  wire logic        i_exposing_line,
	input  wire logic        i_exposing_first_row,
	input  wire logic        i_exposing_every_row,
	input  wire logic        i_trigger_ready_flag,
	input  wire logic        i_pulse_per_second,
	input  wire logic        i_uart_tx,
	output logic             o_uart_rx,
	output logic [3:0]       o_filtered_in,
	output logic [1:0]       o_exposing_signal_mode
);
	localparam int N = io_line_pkg::N_LINES;

	logic [1:0]  pin_index_select;
	logic [3:0]  pin_direction;
	logic [3:0]  pin_polarity_invert;
	logic [3:0]  aux_rail_enable;
	logic [3:0]  input_filter_kind;
	logic [4:0]  pin_drive_select [N];
	logic [15:0] input_filter_width_us [N][2];
	logic [1:0]  exposing_signal_mode;
	logic [1:0]  soft_bit_index;
	logic [3:0]  soft_bits_word;
	logic [2:0]  rx_pin_select;
	logic [3:0]  sync1;
	logic [3:0]  sync2;
	logic [3:0]  all_pin_levels;
	logic [3:0]  pin_value;
	logic [3:0]  driven;
	logic        sensor_exposing_flag;

	logic        wr_en;
	logic        rd_en;
	logic [31:0] next_prdata;
	logic        next_pslverr;

	// two flops before any logic sees the connector
	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			sync1 <= 4'h0;
			sync2 <= 4'h0;
		end else begin
			sync1 <= i_pin;
			sync2 <= sync1;
		end
	end

	// exposing flag derived per mode
	always_comb begin
		case (exposing_signal_mode)
			io_line_pkg::EXP_FIRST_ROW: sensor_exposing_flag = i_exposing_first_row;
			io_line_pkg::EXP_EVERY_ROW: sensor_exposing_flag = i_exposing_every_row;
			default:                    sensor_exposing_flag = i_exposing_line;
		endcase
	end

	// per-line filter and output path
	genvar g;
	generate
		for (g = 0; g < N; g++) begin : g_line
			logic [23:0] cnt;
			logic [23:0] next_cnt;
			logic        filt;
			logic        next_filt;
			logic [23:0] limit;
			logic        raw;
			logic        drv;
			// polarity applied before filtering so status shows logical level
			assign raw = sync2[g] ^ pin_polarity_invert[g];
			// microseconds to clock cycles
			assign limit = 24'(input_filter_width_us[g][input_filter_kind[g]])
				* 24'(io_line_pkg::CYC_PER_US);
			// deglitch: level must hold for width; debounce: follow at once, then
			// ignore further edges for width
			always_comb begin
				next_cnt = cnt;
				next_filt = filt;
				if (input_filter_kind[g] == io_line_pkg::FILT_DEGLITCH) begin
					if (raw == filt) begin
						next_cnt = 24'h0000;
					end else if (cnt + 24'h0001 >= limit) begin
						next_filt = raw;
						next_cnt = 24'h0000;
					end else begin
						next_cnt = cnt + 24'h0001;
					end
				end else begin
					if (cnt != 24'h0000) begin
						next_cnt = cnt - 24'h0001;
					end else if (raw != filt) begin
						next_filt = raw;
						next_cnt = limit;
					end
				end
			end
			always_ff @(posedge i_clk_sys) begin
				if (i_rst) begin
					cnt <= 24'h0000;
					filt <= 1'b0;
				end else begin
					cnt <= next_cnt;
					filt <= next_filt;
				end
			end
			// drive source mux
			always_comb begin
				case (pin_drive_select[g])
					io_line_pkg::SRC_LINE0:      drv = all_pin_levels[0];
					io_line_pkg::SRC_LINE1:      drv = all_pin_levels[1];
					io_line_pkg::SRC_LINE2:      drv = all_pin_levels[2];
					io_line_pkg::SRC_LINE3:      drv = all_pin_levels[3];
					io_line_pkg::SRC_SOFT0:      drv = soft_bits_word[0];
					io_line_pkg::SRC_SOFT1:      drv = soft_bits_word[1];
					io_line_pkg::SRC_SOFT2:      drv = soft_bits_word[2];
					io_line_pkg::SRC_SOFT3:      drv = soft_bits_word[3];
					io_line_pkg::SRC_CNT0:       drv = i_count_unit_running[0];
					io_line_pkg::SRC_CNT1:       drv = i_count_unit_running[1];
					io_line_pkg::SRC_GLUE0:      drv = i_glue_logic_out[0];
					io_line_pkg::SRC_GLUE1:      drv = i_glue_logic_out[1];
					io_line_pkg::SRC_EXPOSING:   drv = sensor_exposing_flag;
					io_line_pkg::SRC_TRIG_READY: drv = i_trigger_ready_flag;
					io_line_pkg::SRC_PPS:        drv = i_pulse_per_second;
					io_line_pkg::SRC_UART_TX:    drv = i_uart_tx;
					default:                     drv = 1'b0;
				endcase
			end
			// loopback of an output line reads its driven value, not the pin
			assign pin_value[g] = drv;
			// output lines report the registered drive, filtered input otherwise
			// registering it keeps line loopback free of combinational loops
			assign all_pin_levels[g] = pin_direction[g] ? driven[g] : filt;
			assign o_filtered_in[g] = filt;
		end
	endgenerate

	// pin driven only in output direction
	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			o_pin <= 4'h0;
			o_pin_oe <= 4'h0;
			driven <= 4'h0;
		end else begin
			o_pin <= (pin_value ^ pin_polarity_invert) & pin_direction;
			o_pin_oe <= pin_direction;
			driven <= pin_value;
		end
	end

	// rx source, off disconnects and idles high
	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			o_uart_rx <= 1'b1;
		end else if (rx_pin_select < 3'h4) begin
			o_uart_rx <= all_pin_levels[rx_pin_select[1:0]];
		end else begin
			o_uart_rx <= 1'b1;
		end
	end

	// rail only on capable lines; external switch is slow, no timing assumed
	assign o_aux_rail_enable = aux_rail_enable & RAIL_CAPABLE;
	assign o_exposing_signal_mode = exposing_signal_mode;

	// apb slave: zero wait states
	assign pready = 1'b1;
	assign wr_en = psel & penable & pwrite;
	assign rd_en = psel & ~penable & ~pwrite;

	function automatic logic addr_ok(input logic [7:0] a);
		return (a[1:0] == 2'b00) && (a <= io_line_pkg::ADDR_RX_SEL);
	endfunction

	// register writes
	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			pin_index_select <= 2'b00;
			pin_direction <= 4'h0;
			pin_polarity_invert <= 4'h0;
			aux_rail_enable <= 4'h0;
			input_filter_kind <= 4'h0;
			exposing_signal_mode <= io_line_pkg::EXP_LINE;
			soft_bit_index <= 2'b00;
			soft_bits_word <= 4'h0;
			rx_pin_select <= io_line_pkg::RX_RESET;
			for (int i = 0; i < N; i++) begin
				pin_drive_select[i] <= io_line_pkg::SRC_RESET;
				input_filter_width_us[i][0] <= io_line_pkg::WIDTH_RESET;
				input_filter_width_us[i][1] <= io_line_pkg::WIDTH_RESET;
			end
		end else if (wr_en) begin
			case (paddr)
				io_line_pkg::ADDR_PIN_SEL: pin_index_select <= pwdata[1:0];
				io_line_pkg::ADDR_LINE_CFG: begin
					pin_direction[pin_index_select] <= pwdata[io_line_pkg::POS_DIR];
					pin_polarity_invert[pin_index_select] <= pwdata[io_line_pkg::POS_INV];
					aux_rail_enable[pin_index_select] <= pwdata[io_line_pkg::POS_RAIL];
					input_filter_kind[pin_index_select] <= pwdata[io_line_pkg::POS_FKIND];
					if (pwdata[io_line_pkg::POS_SRC +: 5] <= 5'h10) begin
						pin_drive_select[pin_index_select] <= pwdata[io_line_pkg::POS_SRC +: 5];
					end
				end
				io_line_pkg::ADDR_FILT_WIDTH: begin
					// width for currently selected line and filter kind
					input_filter_width_us[pin_index_select][input_filter_kind[pin_index_select]]
						<= pwdata[15:0];
				end
				io_line_pkg::ADDR_EXP_MODE: begin
					if (pwdata[1:0] != 2'b11) begin
						exposing_signal_mode <= pwdata[1:0];
					end
				end
				io_line_pkg::ADDR_SOFT_IDX: soft_bit_index <= pwdata[1:0];
				io_line_pkg::ADDR_SOFT_VAL: soft_bits_word[soft_bit_index] <= pwdata[0];
				io_line_pkg::ADDR_SOFT_WORD: soft_bits_word <= pwdata[3:0];
				io_line_pkg::ADDR_RX_SEL: begin
					if (pwdata[2:0] <= 3'h4) begin
						rx_pin_select <= pwdata[2:0];
					end
				end
				default: ;
			endcase
		end
	end

	// read data captured in setup cycle, held through access
	always_comb begin
		next_prdata = prdata;
		next_pslverr = 1'b0;
		if (rd_en) begin
			next_prdata = 32'h0000_0000;
			case (paddr)
				io_line_pkg::ADDR_PIN_SEL: next_prdata[1:0] = pin_index_select;
				io_line_pkg::ADDR_LINE_CFG: begin
					next_prdata[io_line_pkg::POS_DIR] = pin_direction[pin_index_select];
					next_prdata[io_line_pkg::POS_INV] = pin_polarity_invert[pin_index_select];
					next_prdata[io_line_pkg::POS_RAIL] = o_aux_rail_enable[pin_index_select];
					next_prdata[io_line_pkg::POS_FKIND] = input_filter_kind[pin_index_select];
					next_prdata[io_line_pkg::POS_SRC +: 5] = pin_drive_select[pin_index_select];
					next_prdata[io_line_pkg::POS_LEVEL] = all_pin_levels[pin_index_select];
					next_prdata[io_line_pkg::POS_CIRCUIT +: 2] =
						CIRCUIT_MAP[2*pin_index_select +: 2];
				end
				io_line_pkg::ADDR_FILT_WIDTH: next_prdata[15:0] =
					input_filter_width_us[pin_index_select][input_filter_kind[pin_index_select]];
				io_line_pkg::ADDR_LEVELS: next_prdata[3:0] = all_pin_levels;
				io_line_pkg::ADDR_EXP_MODE: next_prdata[1:0] = exposing_signal_mode;
				io_line_pkg::ADDR_SOFT_IDX: next_prdata[1:0] = soft_bit_index;
				io_line_pkg::ADDR_SOFT_VAL: next_prdata[0] = soft_bits_word[soft_bit_index];
				io_line_pkg::ADDR_SOFT_WORD: next_prdata[3:0] = soft_bits_word;
				io_line_pkg::ADDR_RX_SEL: next_prdata[2:0] = rx_pin_select;
				default: next_prdata = 32'h0000_0000;
			endcase
		end
		if (psel & ~penable & ~addr_ok(paddr)) begin
			next_pslverr = 1'b1;
		end else if (psel & penable) begin
			next_pslverr = pslverr;
		end
	end

	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			prdata <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else begin
			prdata <= next_prdata;
			pslverr <= next_pslverr;
		end
	end

	// checks
	a_input_no_drive: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		!pin_direction[0] |=> !o_pin_oe[0] && !o_pin[0])
		else $error("input line driven");
	a_reset_inputs: assert property (@(posedge i_clk_sys)
		i_rst |=> o_pin_oe == 4'h0 && soft_bits_word == 4'h0)
		else $error("reset state wrong");
	a_soft_word_wr: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		wr_en && paddr == io_line_pkg::ADDR_SOFT_WORD |=> soft_bits_word == $past(pwdata[3:0]))
		else $error("soft word write lost");
	a_soft_bit_wr: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		wr_en && paddr == io_line_pkg::ADDR_SOFT_VAL
		|=> soft_bits_word[$past(soft_bit_index)] == $past(pwdata[0]))
		else $error("soft bit write lost");
	a_uart_routed: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		pin_direction[1] && pin_drive_select[1] == io_line_pkg::SRC_UART_TX
		|=> o_pin[1] == ($past(i_uart_tx) ^ $past(pin_polarity_invert[1])))
		else $error("uart tx not on line");
	a_rx_off_idle: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		rx_pin_select == 3'h4 |=> o_uart_rx)
		else $error("rx not disconnected");
	a_levels_read: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		rd_en && paddr == io_line_pkg::ADDR_LEVELS |=> prdata[3:0] == $past(all_pin_levels))
		else $error("levels read wrong");
	a_rail_gate: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		wr_en && paddr == io_line_pkg::ADDR_LINE_CFG
		|=> o_aux_rail_enable[$past(pin_index_select)]
		== ($past(pwdata[io_line_pkg::POS_RAIL]) && RAIL_CAPABLE[$past(pin_index_select)]))
		else $error("rail enable wrong");
	c_output_line: cover property (@(posedge i_clk_sys) o_pin_oe[0] && o_pin[0]);
	c_rx_line2: cover property (@(posedge i_clk_sys) rx_pin_select == 3'h2);
	c_soft_write: cover property (@(posedge i_clk_sys) wr_en && paddr == io_line_pkg::ADDR_SOFT_VAL);
endmodule

// [io_pins_ext.sv]
// behavioural circuits on the connector: drive idle lines, see driven ones
`timescale 1ns/1ps
module io_pins_ext (
	input  wire logic [3:0] i_pin_drive,
	input  wire logic [3:0] i_pin_oe,
	input  wire logic [3:0] i_ext_level,
	output logic      [3:0] o_wire
);
	// a line the camera drives shows its drive; otherwise the outside level wins
	always_comb begin
		for (int n = 0; n < 4; n++) begin
			o_wire[n] = i_pin_oe[n] ? i_pin_drive[n] : i_ext_level[n];
		end
	end
endmodule

// [tb_camera_io_line_control.sv]
// self-checking bench for the camera i/o line control block
`timescale 1ns/1ps
module tb_camera_io_line_control;
	logic        i_clk_sys = 0, i_rst = 1, psel = 0, penable = 0, pwrite = 0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000, prdata;
	logic        pready, pslverr, o_uart_rx;
	logic [3:0]  ext = 4'h0, pin_wire, o_pin, o_pin_oe, o_aux_rail_enable, o_filtered_in, sb;
	logic [9:0]  sv = 10'h000;
	logic [1:0]  o_exposing_signal_mode, md;
	logic [32:0] q[$];
	logic        e, inv;
	int          num_errors = 0, checks = 0, cyc = 0;
	// circuit kinds per line, two bits each: line0 isolated, line1 pull-low
	localparam logic [7:0] circ_map = 8'b00_00_10_01;
	always #5 i_clk_sys = ~i_clk_sys;
	camera_io_line_control #(.CIRCUIT_MAP(circ_map), .RAIL_CAPABLE(4'b0100))
		camera_io_line_control_inst (.i_clk_sys(i_clk_sys), .i_rst(i_rst),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .i_pin(pin_wire), .o_pin(o_pin),
		.o_pin_oe(o_pin_oe), .o_aux_rail_enable(o_aux_rail_enable),
		.i_count_unit_running(sv[1:0]), .i_glue_logic_out(sv[3:2]), .i_exposing_line(sv[4]),
		.i_exposing_first_row(sv[5]), .i_exposing_every_row(sv[6]),
		.i_trigger_ready_flag(sv[7]), .i_pulse_per_second(sv[8]), .i_uart_tx(sv[9]),
		.o_uart_rx(o_uart_rx), .o_filtered_in(o_filtered_in),
		.o_exposing_signal_mode(o_exposing_signal_mode));
	io_pins_ext io_pins_ext_inst (.i_pin_drive(o_pin), .i_pin_oe(o_pin_oe),
		.i_ext_level(ext), .o_wire(pin_wire));
	task automatic chk_pin(input logic [32:0] got, input logic [32:0] exp);
		checks++;
		if (got !== exp) begin
			num_errors++;
			$display("Error t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic chk_rd(input logic [32:0] exp);
		chk_pin({pslverr, prdata}, exp);
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge i_clk_sys);
	endtask
	// one apb transfer; a read leaves its expectation for the monitor
	task automatic apb(input logic w, input logic [7:0] a, input logic [32:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d[31:0];
		if (!w) q.push_back(d);
		@(posedge i_clk_sys);
		penable <= 1'b1;
		@(posedge i_clk_sys);
		while (pready !== 1'b1) @(posedge i_clk_sys);
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge i_clk_sys);
	endtask
	always @(posedge i_clk_sys) begin
		if (psel && penable && pready === 1'b1 && !pwrite && q.size() > 0) chk_rd(q.pop_front());
	end
	// source value a line should carry, from the bench's own view of the inputs
	function automatic logic src_val(input int s);
		case (s)
			0: src_val = 1'b0;
			1: src_val = ext[0];
			3: src_val = ext[2];
			4: src_val = ext[3];
			13: src_val = sv[4 + md];
			default: src_val = s < 9 ? sb[s - 5] : (s < 13 ? sv[s - 9] : sv[s - 7]);
		endcase
	endfunction
	task automatic results;
		$display("errors=%0d checks=%0d", num_errors, checks);
		if (num_errors == 0 && checks > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	always @(posedge i_clk_sys) begin
		cyc++;
		if (cyc == 20000) begin
			num_errors++;
			results();
		end
	end
	initial begin
		void'($urandom(14));
		tick(12);
		i_rst <= 1'b0;
		tick(1);
		chk_pin({o_pin_oe, o_pin, o_aux_rail_enable, o_uart_rx}, 33'h0_0000_0001);
		for (int n = 0; n < 4; n++) begin
			apb(1, 8'h00, n);
			apb(0, 8'h04, 33'(32'(circ_map[2*n +: 2]) << 24));
			apb(0, 8'h08, 33'h0_0000_0000);
		end
		apb(0, 8'h1C, 33'h0_0000_0000);
		for (int i = 0; i < 4; i++) begin
			apb(1, 8'h14, i);
			sb[i] = 1'($urandom);
			apb(1, 8'h18, sb[i]);
			apb(0, 8'h18, sb[i]);
		end
		apb(0, 8'h1C, sb);
		sb = 4'($urandom);
		apb(1, 8'h1C, sb);
		for (int i = 0; i < 4; i++) begin
			apb(1, 8'h14, i);
			apb(0, 8'h18, sb[i]);
		end
		ext <= 4'($urandom);
		tick(6);
		for (int r = 0; r < 5; r++) begin
			apb(1, 8'h20, r);
			tick(4);
			chk_pin(o_uart_rx, r == 4 ? 1'b1 : ext[r]);
		end
		apb(1, 8'h20, 33'h0_0000_0005);
		apb(0, 8'h20, 33'h0_0000_0004);
		apb(0, 8'h0C, ext);
		apb(1, 8'h00, 33'h0_0000_0001);
		for (int s = 0; s <= 16; s++) begin
			if (s == 2) continue;
			sv <= 10'($urandom);
			ext[0] <= 1'($urandom);
			md = 2'($urandom % 3);
			inv = 1'($urandom);
			apb(1, 8'h10, md);
			apb(1, 8'h04, (s << 8) | (inv << 1) | 1);
			tick(4);
			e = src_val(s);
			chk_pin({o_pin_oe[1], o_pin[1]}, {1'b1, e ^ inv});
			apb(0, 8'h04, 32'h0200_0001 | (e << 16) | (s << 8) | (inv << 1));
		end
		apb(0, 8'h0C, {ext[3:2], e, ext[0]});
		apb(1, 8'h10, 33'h0_0000_0003);
		apb(0, 8'h10, md);
		chk_pin(o_exposing_signal_mode, md);
		apb(1, 8'h04, 33'h0_0000_0502);
		tick(3);
		chk_pin({o_pin_oe[1], o_pin[1]}, 2'b00);
		apb(1, 8'h00, 33'h0_0000_0003);
		apb(1, 8'h04, 33'h0_0000_0002);
		tick(6);
		chk_pin(o_filtered_in[3], !ext[3]);
		apb(1, 8'h00, 33'h0_0000_0002);
		apb(1, 8'h04, 33'h0_0000_0004);
		apb(1, 8'h00, 33'h0_0000_0000);
		apb(1, 8'h04, 33'h0_0000_0004);
		chk_pin(o_aux_rail_enable, 4'b0100);
		apb(0, 8'h30, 33'h1_0000_0000);
		// line 0 deglitch, 1 us: a 50-cycle pulse must not pass
		apb(1, 8'h04, 33'h0_0000_0000);
		apb(1, 8'h08, 33'h0_0000_0001);
		ext[0] <= 1'b0;
		tick(150);
		ext[0] <= 1'b1;
		tick(50);
		ext[0] <= 1'b0;
		tick(10);
		chk_pin(o_filtered_in[0], 1'b0);
		ext[0] <= 1'b1;
		tick(150);
		chk_pin(o_filtered_in[0], 1'b1);
		apb(1, 8'h04, 33'h0_0000_0008);
		apb(0, 8'h08, 33'h0_0000_0000);
		apb(1, 8'h08, 33'h0_0000_0001);
		ext[0] <= 1'b0;
		tick(6);
		chk_pin(o_filtered_in[0], 1'b0);
		ext[0] <= 1'b1;
		tick(20);
		chk_pin(o_filtered_in[0], 1'b0);
		tick(150);
		chk_pin(o_filtered_in[0], 1'b1);
		tick(2);
		results();
	end
endmodule
